/* inc/emcsa_pkg.sv */
// constants, state type and space decode for the wide memory interface
// control block; pclk is taken to be the CPU clock
package emcsa_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  ACCESS_OFS = 8'h04;
    localparam logic [7:0]  STATUS_OFS = 8'h08;
    // control register fields
    localparam int          DIV_LSB    = 0;
    localparam int          RSEL_LSB   = 2;
    localparam int          MTYPE_LSB  = 6;
    localparam int          SREF_BIT   = 14;
    localparam int          GPO_BIT    = 15;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    // access register fields
    localparam int          WR_BIT     = 0;
    localparam int          SPACE_LSB  = 28;
    // status register fields
    localparam int          ST_SRC_LSB = 0;
    localparam int          ST_PEND    = 2;
    localparam int          ST_ACK     = 3;
    localparam int          ST_HOLD    = 4;
    localparam int          ST_BREQ    = 5;
    // divided clock factor codes
    localparam logic [1:0]  DIV_BY1    = 2'h0;
    localparam logic [1:0]  DIV_BY2    = 2'h1;
    localparam logic [1:0]  DIV_BY4    = 2'h2;
    // strap codes for the interface clock source
    localparam logic [1:0]  SRC_EXT    = 2'h0;
    localparam logic [1:0]  SRC_CPU4   = 2'h1;
    localparam logic [1:0]  SRC_CPU6   = 2'h2;
    // last pclk count (from 0) of each source half period: cpu/4 and cpu/6
    localparam logic [1:0]  CPU4_LIM   = 2'h1;
    localparam logic [1:0]  CPU6_LIM   = 2'h2;
    // memory type codes per space
    localparam logic [1:0]  MT_ASYNC   = 2'h0;
    localparam logic [1:0]  MT_SDRAM   = 2'h1;
    localparam logic [1:0]  MT_SYNC    = 2'h2;
    // access phases: 0 setup, 1 strobe, 2 hold
    localparam logic [1:0]  LAST_PHASE = 2'h2;
    // top nibble 8..b of the word address selects spaces 0..3
    localparam logic [1:0]  SPACE_BASE = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_HELD   = 3'b100
    } emcsa_state_type;

    // one-hot chip enable from the top four word address bits
    function automatic logic [3:0] emcsa_ce_decode(input logic [3:0] top);
        emcsa_ce_decode = 4'h0;
        if (top[3:2] == SPACE_BASE) emcsa_ce_decode[top[1:0]] = 1'b1;
    endfunction : emcsa_ce_decode
endpackage : emcsa_pkg

/* rtl/emcsa_clkgen.sv */
// clock generator: strap capture, source ticks and both output clocks
// assumes pclk is the CPU clock and the external clock is below pclk/4
`timescale 1ns/1ns
module emcsa_clkgen
    import emcsa_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // pins and control
    input  wire logic       ext_interface_clock_in,
    input  wire logic [1:0] clock_select_straps,
    input  wire logic [1:0] div_sel,
    // results
    output logic            full_rate_clock_out,
    output logic            divided_clock_out,
    output logic            iface_en,
    output logic [1:0]      src_sel
);
    logic [2:0] ext_q;
    logic [1:0] strap1_q, strap2_q, settle_q, cnt_q, dcnt_q, lim;
    logic       cap_q, tick, div_tog;

    // synchronisers; ext_q[2] is the edge history behind stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q    <= 3'h0;
            strap1_q <= 2'h0;
            strap2_q <= 2'h0;
        end else begin
            ext_q    <= {ext_q[1:0], ext_interface_clock_in};
            strap1_q <= clock_select_straps;
            strap2_q <= strap1_q;
        end
    end

    // straps are taken once, after the synchroniser has filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 2'h0;
            cap_q    <= 1'b0;
            src_sel  <= SRC_EXT;
        end else begin
            settle_q <= {settle_q[0], 1'b1};
            if (settle_q[1] && !cap_q) begin
                cap_q   <= 1'b1;
                src_sel <= (strap2_q == SRC_CPU4 || strap2_q == SRC_CPU6)
                           ? strap2_q : SRC_EXT;
            end
        end
    end

    // one tick per source clock edge, both edges of the external pin
    assign lim  = (src_sel == SRC_CPU4) ? CPU4_LIM : CPU6_LIM;
    assign tick = cap_q && ((src_sel == SRC_EXT) ? (ext_q[1] ^ ext_q[2])
                                                 : (cnt_q == lim));
    assign iface_en = tick && !full_rate_clock_out;

    always_comb begin
        case (div_sel)
            DIV_BY2: div_tog = dcnt_q[0];
            DIV_BY4: div_tog = &dcnt_q;
            default: div_tog = 1'b1;
        endcase
    end

    // output clocks toggle on ticks only, so no gated clock exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q               <= 2'h0;
            dcnt_q              <= 2'h0;
            full_rate_clock_out <= 1'b0;
            divided_clock_out   <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == lim) ? 2'h0 : cnt_q + 2'h1;
            if (tick) begin
                full_rate_clock_out <= ~full_rate_clock_out;
                dcnt_q              <= dcnt_q + 2'h1;
                if (div_tog) divided_clock_out <= ~divided_clock_out;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    full_follows_a: assert property (
        ##1 ((full_rate_clock_out != $past(full_rate_clock_out)) == $past(tick)))
        else $error("full rate clock out of step with source");
    div_four_a: assert property (
        (div_sel == DIV_BY4 && tick && dcnt_q != 2'h3) |=> $stable(divided_clock_out))
        else $error("divide by four toggled early");
    strap_default_a: assert property (
        ($rose(cap_q) && $past(strap2_q) == 2'h3) |-> src_sel == SRC_EXT)
        else $error("unstrapped source is not the external clock");
endmodule : emcsa_clkgen

/* rtl/emcsa_strobe_mux.sv */
// strobe role mux: maps access phase onto the three shared strobe pins
// assumes type, select and direction are held for a whole access
`timescale 1ns/1ns
module emcsa_strobe_mux
    import emcsa_pkg::*;
(
    // access state
    input  wire logic       active,
    input  wire logic [1:0] phase,
    input  wire logic       is_write,
    input  wire logic       space3,
    // space setup
    input  wire logic [1:0] mem_type,
    input  wire logic       read_strobe_select,
    // active-low pin values
    output logic            read_pin_n,
    output logic            oe_pin_n,
    output logic            write_pin_n,
    output logic            fifo_oe_n
);
    logic ph0, ph1, rd1;
    logic async_read_strobe, async_output_strobe, async_write_strobe;
    logic sdram_column_strobe, sdram_row_strobe, sdram_write_strobe;
    logic sync_address_strobe, sync_read_strobe;
    logic sync_output_strobe, sync_write_strobe;

    // every role of every pin, active high
    assign ph0 = active && phase == 2'h0;
    assign ph1 = active && phase == 2'h1;
    assign rd1 = ph1 && !is_write;
    assign async_read_strobe   = rd1;
    assign async_output_strobe = rd1;
    assign async_write_strobe  = ph1 && is_write;
    assign sdram_row_strobe    = ph0;
    assign sdram_column_strobe = ph1;
    assign sdram_write_strobe  = ph1 && is_write;
    assign sync_address_strobe = ph0 && !read_strobe_select;
    assign sync_read_strobe    = rd1 && read_strobe_select;
    assign sync_output_strobe  = rd1;
    assign sync_write_strobe   = ph0 && is_write;

    // pin role follows the memory type; reserved type drives nothing
    always_comb begin
        read_pin_n  = 1'b1;
        oe_pin_n    = 1'b1;
        write_pin_n = 1'b1;
        case (mem_type)
            MT_ASYNC: begin
                read_pin_n  = ~async_read_strobe;
                oe_pin_n    = ~async_output_strobe;
                write_pin_n = ~async_write_strobe;
            end
            MT_SDRAM: begin
                read_pin_n  = ~sdram_column_strobe;
                oe_pin_n    = ~sdram_row_strobe;
                write_pin_n = ~sdram_write_strobe;
            end
            MT_SYNC: begin
                read_pin_n  = ~(sync_address_strobe | sync_read_strobe);
                oe_pin_n    = ~sync_output_strobe;
                write_pin_n = ~sync_write_strobe;
            end
            default: ;
        endcase
    end

    // dedicated fifo output enable, only for synchronous space 3
    assign fifo_oe_n = ~(space3 && mem_type == MT_SYNC && sync_output_strobe);
endmodule : emcsa_strobe_mux

/* rtl/emcsa_top.sv */
// wide memory interface control: clocks, strobe roles, bus hold
// arbitration and chip enables, with an APB register slave
// assumes pclk is the CPU clock and all pins but APB are asynchronous
`timescale 1ns/1ns
module emcsa_top
    import emcsa_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // clock pins
    input  wire logic        ext_interface_clock_in,
    input  wire logic [1:0]  clock_select_straps,
    output logic             full_rate_clock_out,
    output logic             divided_clock_out,
    // arbitration pins
    input  wire logic        hold_request_in,
    output logic             hold_acknowledge_out,
    output logic             bus_request_out,
    // memory control pins
    output logic [3:0]       chip_select_n,
    output logic             shared_read_pin_n,
    output logic             shared_oe_pin_n,
    output logic             shared_write_pin_n,
    output logic             space3_fifo_output_strobe_n,
    output logic             sdram_clock_gate_out,
    output logic             bus_oe
);
    emcsa_state_type st_q;
    logic [15:0] ctrl_q;
    logic [3:0]  acc_top_q;
    logic [3:0]  acc_ce;
    logic [1:0]  acc_type_q;
    logic [1:0]  phase_q;
    logic [1:0]  src_sel;
    logic [3:0]  is_sdram;
    logic        acc_wr_q;
    logic        acc_rsel_q;
    logic        pending_q;
    logic        hold1_q;
    logic        hold2_q;
    logic        iface_en;
    logic        wr_en;
    logic        start_ok;
    logic        acc_done;
    logic        sdram_fitted;
    logic        mux_rd_n;
    logic        mux_oe_n;
    logic        mux_wr_n;
    logic        mux_fifo_n;
    logic        chip_select_space3;

    // apb: zero wait states, every transfer ends in its first access cycle
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;

    // ---- clock source and output clocks
    emcsa_clkgen u_clkgen (
        .pclk                   (pclk),
        .presetn                (presetn),
        .ext_interface_clock_in (ext_interface_clock_in),
        .clock_select_straps    (clock_select_straps),
        .div_sel                (ctrl_q[DIV_LSB +: 2]),
        .full_rate_clock_out    (full_rate_clock_out),
        .divided_clock_out      (divided_clock_out),
        .iface_en               (iface_en),
        .src_sel                (src_sel)
    );

    // hold request is a pin: two flops before anything looks at it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold1_q <= 1'b0;
            hold2_q <= 1'b0;
        end else begin
            hold1_q <= hold_request_in;
            hold2_q <= hold1_q;
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_q <= pwdata[15:0];
        end
    end

    // an access write is taken only when no access is pending and decoding to a space
    assign start_ok = wr_en && paddr == ACCESS_OFS && !pending_q
                      && emcsa_ce_decode(pwdata[SPACE_LSB +: 4]) != 4'h0;
    assign acc_done = st_q == ST_ACCESS && iface_en && phase_q == LAST_PHASE;

    // access request; type and select are frozen for the whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q  <= 1'b0;
            acc_top_q  <= 4'h0;
            acc_wr_q   <= 1'b0;
            acc_type_q <= MT_ASYNC;
            acc_rsel_q <= 1'b0;
        end else if (start_ok) begin
            pending_q  <= 1'b1;
            acc_top_q  <= pwdata[SPACE_LSB +: 4];
            acc_wr_q   <= pwdata[WR_BIT];
            acc_type_q <= ctrl_q[MTYPE_LSB + 2 * pwdata[SPACE_LSB +: 2] +: 2];
            acc_rsel_q <= ctrl_q[RSEL_LSB + pwdata[SPACE_LSB +: 2]];
        end else if (acc_done) begin
            pending_q <= 1'b0;
        end
    end

    // arbitration: the host is served only between accesses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= ST_IDLE;
            phase_q <= 2'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    phase_q <= 2'h0;
                    if (hold2_q) st_q <= ST_HELD;
                    else if (pending_q) st_q <= ST_ACCESS;
                end
                ST_ACCESS: begin
                    if (iface_en) phase_q <= phase_q + 2'h1;
                    if (acc_done) st_q <= ST_IDLE;
                end
                ST_HELD: begin
                    if (!hold2_q) st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // acknowledge lags the release of the pins by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_oe               <= 1'b1;
            hold_acknowledge_out <= 1'b0;
            bus_request_out      <= 1'b0;
        end else begin
            bus_oe               <= !(st_q == ST_HELD && hold2_q);
            hold_acknowledge_out <= st_q == ST_HELD && hold2_q && !bus_oe;
            bus_request_out      <= pending_q && st_q == ST_HELD;
        end
    end

    // ---- pin roles
    assign acc_ce = emcsa_ce_decode(acc_top_q);

    emcsa_strobe_mux u_strobe (
        .active             (st_q == ST_ACCESS),
        .phase              (phase_q),
        .is_write           (acc_wr_q),
        .space3             (acc_ce[3]),
        .mem_type           (acc_type_q),
        .read_strobe_select (acc_rsel_q),
        .read_pin_n         (mux_rd_n),
        .oe_pin_n           (mux_oe_n),
        .write_pin_n        (mux_wr_n),
        .fifo_oe_n          (mux_fifo_n)
    );

    // which spaces hold sdram, for the clock gate pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_space
            assign is_sdram[gi] = ctrl_q[MTYPE_LSB + 2 * gi +: 2] == MT_SDRAM;
        end
    endgenerate
    assign sdram_fitted = |is_sdram;

    // pins come from flops so the memories never see decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_select_n               <= 4'hf;
            shared_read_pin_n           <= 1'b1;
            shared_oe_pin_n             <= 1'b1;
            shared_write_pin_n          <= 1'b1;
            space3_fifo_output_strobe_n <= 1'b1;
        end else begin
            chip_select_n               <= (st_q == ST_ACCESS) ? ~acc_ce : 4'hf;
            shared_read_pin_n           <= mux_rd_n;
            shared_oe_pin_n             <= mux_oe_n;
            shared_write_pin_n          <= mux_wr_n;
            space3_fifo_output_strobe_n <= mux_fifo_n;
        end
    end
    assign chip_select_space3 = ~chip_select_n[3];

    // clock gate: self refresh drops it, otherwise a general output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdram_clock_gate_out <= 1'b0;
        end else begin
            sdram_clock_gate_out <= sdram_fitted ? ~ctrl_q[SREF_BIT]
                                                 : ctrl_q[GPO_BIT];
        end
    end

    // read data is sampled in the setup cycle, so it is one cycle old
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            case (paddr)
                CTRL_OFS: prdata[15:0] <= ctrl_q;
                ACCESS_OFS: begin
                    prdata[SPACE_LSB +: 4] <= acc_top_q;
                    prdata[WR_BIT]         <= acc_wr_q;
                end
                STATUS_OFS: begin
                    prdata[ST_SRC_LSB +: 2] <= src_sel;
                    prdata[ST_PEND]         <= pending_q;
                    prdata[ST_ACK]          <= hold_acknowledge_out;
                    prdata[ST_HOLD]         <= hold2_q;
                    prdata[ST_BREQ]         <= bus_request_out;
                end
                default: pslverr <= 1'b1;
            endcase
        end
    end

    // ---- checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_hold_seen;
        st_q == ST_HELD && hold2_q;
    endsequence
    sequence seq_released;
        !bus_oe ##1 hold_acknowledge_out;
    endsequence
    sequence seq_sync_addr;
        st_q == ST_ACCESS && acc_type_q == MT_SYNC && !acc_rsel_q
        && phase_q == 2'h0;
    endsequence

    hold_answer_a: assert property (
        seq_hold_seen ##1 seq_hold_seen |-> ##1 hold_acknowledge_out)
        else $error("held bus not acknowledged");
    ack_after_release_a: assert property (
        $rose(hold_acknowledge_out) |-> $past(!bus_oe) && $past(st_q == ST_HELD))
        else $error("acknowledge before pins were released");
    ack_withdraw_a: assert property (
        (hold_acknowledge_out && !hold2_q) |=> !hold_acknowledge_out)
        else $error("acknowledge kept after request withdrawn");
    release_steps_a: assert property (
        (st_q == ST_HELD && hold2_q && !bus_oe) |=> seq_released or !hold2_q)
        else $error("release sequence broken");
    one_select_a: assert property (
        $onehot0(~chip_select_n) && (chip_select_n == 4'hf || bus_oe))
        else $error("chip enables not one-hot or driven while released");
    select_decode_a: assert property (
        (st_q == ST_ACCESS) |=> chip_select_n == ~emcsa_ce_decode($past(acc_top_q)))
        else $error("chip enable does not match address bits");
    bus_request_a: assert property (
        (pending_q && st_q == ST_HELD) |=> bus_request_out)
        else $error("bus request missing while waiting");
    clock_gate_a: assert property (
        ##1 sdram_clock_gate_out == ($past(sdram_fitted) ? !$past(ctrl_q[SREF_BIT])
                                                         : $past(ctrl_q[GPO_BIT])))
        else $error("sdram clock gate wrong");
    sync_addr_a: assert property (
        seq_sync_addr |=> !shared_read_pin_n)
        else $error("address strobe role missing");
    fifo_space3_a: assert property (
        !space3_fifo_output_strobe_n |-> chip_select_space3 || $past(acc_ce[3]))
        else $error("fifo strobe outside space 3");
    async_write_a: assert property (
        (st_q == ST_ACCESS && acc_type_q == MT_ASYNC && phase_q == 2'h1 && acc_wr_q)
        |=> !shared_write_pin_n && shared_read_pin_n)
        else $error("async write strobe role wrong");
endmodule : emcsa_top

/* tb/emcsa_bench.sv */
// bench: apb register tests, clock rates, strobe roles and bus hold
// assumes the partner model supplies the source clock and host request
`timescale 1ns/1ns
module emcsa_bench import emcsa_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, want = 1'b0, pready, pslverr, err, ext_clk, hreq;
    logic        ack, breq, boe, fclk, dclk, rdp, oep, wrp, fifop, gate;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  straps = 2'h0;
    logic [3:0]  csn, cs_seen = 4'hf, pin_seen = 4'hf;
    logic [1:0]  st_v[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [15:0] gv[4] = '{16'h8000, 16'h0000, 16'h0040, 16'h4040};
    int          per_v[4] = '{10, 6, 10, 4};
    int          fails = 0, checks_done = 0, cyc = 0, olap = 0, p;

    emcsa_top u_emcsa_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_interface_clock_in(ext_clk),
        .clock_select_straps(straps), .full_rate_clock_out(fclk), .divided_clock_out(dclk),
        .hold_request_in(hreq), .hold_acknowledge_out(ack), .bus_request_out(breq),
        .chip_select_n(csn), .shared_read_pin_n(rdp), .shared_oe_pin_n(oep),
        .shared_write_pin_n(wrp), .space3_fifo_output_strobe_n(fifop),
        .sdram_clock_gate_out(gate), .bus_oe(boe));
    emcsa_partner u_emcsa_partner (.want_bus(want), .hold_acknowledge_out(ack),
        .hold_request_in(hreq), .ext_interface_clock_in(ext_clk));

    // 10 MHz clock
    always #50 pclk = ~pclk;
    // pins sampled mid-cycle where they are settled; low bits stick
    always @(negedge pclk) begin
        cs_seen &= csn;
        pin_seen &= {fifop, wrp, oep, rdp};
        if (ack === 1'b1 && csn !== 4'hf) olap++;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end

    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer, request held until pready is seen
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rst(input logic [1:0] s);
        @(posedge pclk);
        presetn <= 1'b0;
        straps <= s;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // the strap choice only lands three edges after release
        repeat (3) @(posedge pclk);
    endtask : rst
    task wait_done;
        int n;
        n = 0;
        do begin
            apb(STATUS_OFS, 1'b0, 32'h0);
            n++;
        end while (rd[ST_PEND] !== 1'b0 && n < 100);
        chk("pending", 32'h0, {31'h0, rd[ST_PEND]});
    endtask : wait_done
    task run_case(input logic [1:0] sp, mt, input logic sel, wr, input logic [3:0] m);
        apb(CTRL_OFS, 1'b1, (32'(mt) << (MTYPE_LSB + 2 * sp)) | (32'(sel) << (RSEL_LSB + sp)));
        cs_seen = 4'hf;
        pin_seen = 4'hf;
        apb(ACCESS_OFS, 1'b1, {2'b10, sp, 27'h0, wr});
        wait_done();
        chk("chip select", {28'h0, 4'hf ^ (4'h1 << sp)}, {28'h0, cs_seen});
        chk("strobes {fifo,wr,oe,rd}", {28'h0, m}, {28'h0, ~pin_seen});
    endtask : run_case
    // period of a rising edge train, second full period after the call
    task per(input logic sel, output int q);
        logic last, cur;
        int n, r, n2;
        last = 1'b1;
        n = 0;
        r = 0;
        n2 = 0;
        while (r < 3 && n < 400) begin
            @(negedge pclk);
            n++;
            cur = sel ? dclk : fclk;
            if (cur === 1'b1 && last === 1'b0) r++;
            if (r == 2 && n2 == 0) n2 = n;
            last = cur;
        end
        q = n - n2;
    endtask : per

    // main sequence, strap cpu/4 is left in force after the first test
    initial begin
        for (int i = 0; i < 4; i++) begin
            rst(st_v[i]);
            apb(STATUS_OFS, 1'b0, 32'h0);
            chk("source", {30'h0, (st_v[i] == 2'h3) ? 2'h0 : st_v[i]}, {30'h0, rd[1:0]});
            per(1'b0, p);
            chk("full period", per_v[i], p);
        end
        $display("clock source test done");
        for (int i = 0; i < 3; i++) begin
            apb(CTRL_OFS, 1'b1, 32'(i));
            per(1'b1, p);
            chk("divided period", 4 << i, p);
        end
        $display("divider test done");
        run_case(2'h0, MT_ASYNC, 1'b0, 1'b0, 4'b0011);
        run_case(2'h1, MT_ASYNC, 1'b0, 1'b1, 4'b0100);
        run_case(2'h2, MT_SDRAM, 1'b0, 1'b0, 4'b0011);
        run_case(2'h2, MT_SDRAM, 1'b0, 1'b1, 4'b0111);
        run_case(2'h1, MT_SYNC, 1'b0, 1'b1, 4'b0101);
        run_case(2'h1, MT_SYNC, 1'b1, 1'b1, 4'b0100);
        run_case(2'h3, MT_SYNC, 1'b1, 1'b0, 4'b1011);
        run_case(2'h3, MT_ASYNC, 1'b0, 1'b0, 4'b0011);
        $display("strobe role test done");
        for (int i = 0; i < 4; i++) begin
            apb(CTRL_OFS, 1'b1, {16'h0, gv[i]});
            repeat (2) @(negedge pclk);
            chk("clock gate", {31'h0, !i[0]}, {31'h0, gate});
        end
        $display("clock gate test done");
        want <= 1'b1;
        for (int n = 0; n < 50 && ack !== 1'b1; n++) @(negedge pclk);
        chk("hold ack", 32'h1, {31'h0, ack});
        chk("bus released", 32'h0, {31'h0, boe});
        apb(ACCESS_OFS, 1'b1, {4'h8, 28'h0});
        apb(STATUS_OFS, 1'b0, 32'h0);
        chk("bus request", 32'h1, {31'h0, breq});
        chk("held pending", 32'h1, {31'h0, rd[ST_PEND]});
        want <= 1'b0;
        wait_done();
        chk("ack dropped", 32'h0, {31'h0, ack});
        chk("overlap", 32'h0, 32'(olap));
        chk("bus request off", 32'h0, {31'h0, breq});
        apb(8'h0c, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("hold and unmapped test done");
        conclude();
    end
endmodule : emcsa_bench

/* tb/emcsa_partner.sv */
// partner: free running source clock and a host that borrows the bus
// assumes the bench raises want_bus to ask for the bus
`timescale 1ns/1ns
module emcsa_partner (
    // host side
    input  wire logic want_bus,
    input  wire logic hold_acknowledge_out,
    // pins into the device
    output logic      hold_request_in,
    output logic      ext_interface_clock_in
);
    // oscillator runs free, off phase from pclk so no edge lines up
    initial begin
        ext_interface_clock_in = 1'b0;
        #37;
        forever #500 ext_interface_clock_in = ~ext_interface_clock_in;
    end
    // a host never withdraws its request before it is granted
    initial begin
        hold_request_in = 1'b0;
        forever begin
            @(posedge want_bus);
            #17 hold_request_in = 1'b1;
            @(negedge want_bus);
            wait (hold_acknowledge_out === 1'b1);
            #17 hold_request_in = 1'b0;
        end
    end
endmodule : emcsa_partner
